// ===== mqfe_fifo.sv
// Purpose: constants for the queue block and one 16-word queue store
// Assumes: single clock, synchronous active-low reset
// Notes:   head word comes out of a register, refreshed every cycle
package mqfe_pkg;
    localparam int NUM_QUEUES = 4;
    localparam int QSEL_W     = 2;
    localparam int DEV_W      = 3;
    localparam int DATA_W     = 18;
    localparam int FIFO_DEPTH = 16;
    localparam int CNT_W      = 5;
    localparam int AF_OFFSET  = 4;
    localparam int AE_OFFSET  = 4;
    localparam logic [CNT_W-1:0] AF_THR = 5'h0c;
    localparam logic [CNT_W-1:0] AE_THR = 5'h04;
    localparam logic [QSEL_W-1:0] QSEL_RST = 2'h0;
    localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;
    localparam logic [NUM_QUEUES-1:0] FLAG_RST = 4'hf;
endpackage

`timescale 1ns/1ns
module mqfe_fifo
    import mqfe_pkg::*;
#(
    parameter int WIDTH = DATA_W,
    parameter int DEPTH = FIFO_DEPTH
)
(
    // clock and reset
    input  wire logic                     core_clk,
    input  wire logic                     reset_n,
    // filling side
    input  wire logic                     in_valid,
    output logic                          in_ready,
    input  wire logic [WIDTH-1:0]         in_data,
    // draining side
    output logic                          out_valid,
    input  wire logic                     out_ready,
    output logic [WIDTH-1:0]              out_data,
    output logic [$clog2(DEPTH):0]        count
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW-1:0]    rd_ptr_next;
    logic [AW:0]      count_reg;
    logic [AW:0]      count_next;
    logic [WIDTH-1:0] head_reg;
    logic             push;
    logic             pop;
    logic             bypass;

    assign in_ready    = (count_reg != DEPTH[AW:0]);
    assign out_valid   = (count_reg != '0);
    assign push        = in_valid && in_ready;
    assign pop         = out_valid && out_ready;
    assign rd_ptr_next = pop ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
    assign count_next  = count_reg + {{AW{1'b0}}, push}
                         - {{AW{1'b0}}, pop};
    // a word written into the slot read next must show up as head at once
    assign bypass      = push && (wr_ptr_reg == rd_ptr_next);
    assign out_data    = head_reg;
    assign count       = count_reg;

    always_ff @(posedge core_clk)
    begin
        if (push)
            mem_reg[wr_ptr_reg] <= in_data;
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
            head_reg   <= '0;
        end
        else
        begin
            wr_ptr_reg <= push ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
            rd_ptr_reg <= rd_ptr_next;
            count_reg  <= count_next;
            head_reg   <= bypass ? in_data : mem_reg[rd_ptr_next];
        end
    end
endmodule

// ===== mqfe_top.sv
// Purpose: four-queue store with read/write queue selection, flags
//          and shared status buses for devices in expansion
// Assumes: write and read controllers run on core_clk
// Notes:   tri-state pins are split into out and output enable
//
// What this block does
// - idle queue selection stops output refill
// - idle queue empty, last word held, flag inactive
// - new queue head falls through without enable
// - almost-full asserts two cycles after write
// - almost-full follows new write queue, two cycles
// - almost-full releases one cycle after read
// - almost-empty asserts two cycles after read
// - almost-empty releases one cycle after write
// - unselected reader device floats data and flags
// - unselected writer device floats almost-full flag
// - empty status bus follows selection one cycle
// - status bit index equals queue number
// - old owner floats bus as new drives
// - writer picks full-bus device, shown next cycle
// - full-bus bit rises one cycle after read
// - write to read queue raises empty flag
// - valid flag high means output word invalid
`timescale 1ns/1ns
module mqfe_top
    import mqfe_pkg::*;
(
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  reset_n,
    // board straps
    input  wire logic [DEV_W-1:0]      device_id_pin,
    input  wire logic                  full_expansion_in,
    input  wire logic                  empty_expansion_in,
    output logic                       full_expansion_out,
    output logic                       empty_expansion_out,
    // write port
    input  wire logic                  wr_sel_en,
    input  wire logic                  paf_sel_en,
    input  wire logic [DEV_W-1:0]      wr_sel_dev,
    input  wire logic [QSEL_W-1:0]     wr_sel_queue,
    input  wire logic                  wr_en,
    input  wire logic [DATA_W-1:0]     wr_data,
    output logic                       wr_ready,
    output logic                       almost_full_flag,
    output logic                       almost_full_flag_oe,
    output logic [NUM_QUEUES-1:0]      almost_full_status_bus,
    output logic                       almost_full_status_bus_oe,
    // read port
    input  wire logic                  rd_sel_en,
    input  wire logic                  pae_sel_en,
    input  wire logic [DEV_W-1:0]      rd_sel_dev,
    input  wire logic [QSEL_W-1:0]     rd_sel_queue,
    input  wire logic                  rd_sel_null,
    input  wire logic                  rd_en,
    output logic [DATA_W-1:0]          data_out,
    output logic                       data_out_oe,
    output logic                       output_valid_flag,
    output logic                       output_valid_flag_oe,
    output logic                       almost_empty_flag,
    output logic                       almost_empty_flag_oe,
    output logic [NUM_QUEUES-1:0]      almost_empty_status_bus,
    output logic                       almost_empty_status_bus_oe
);
    function automatic logic [CNT_W-1:0] cnt_after(
        input logic [CNT_W-1:0] cnt,
        input logic             inc,
        input logic             dec
    );
        cnt_after = cnt + {{(CNT_W-1){1'b0}}, inc}
                    - {{(CNT_W-1){1'b0}}, dec};
    endfunction

    // strap synchronisers
    logic [DEV_W-1:0]      id_s1_reg;
    logic [DEV_W-1:0]      id_reg;
    logic [1:0]            xin_s1_reg;
    logic [1:0]            xin_reg;
    logic                  init_done_reg;
    // selection state
    logic [QSEL_W-1:0]     wr_q_reg;
    logic                  wr_own_reg;
    logic [QSEL_W-1:0]     rd_q_reg;
    logic                  rd_null_reg;
    logic                  rd_own_reg;
    logic                  pend_reg;
    logic [QSEL_W-1:0]     pend_q_reg;
    logic                  pend_null_reg;
    logic                  pend_own_reg;
    logic                  first_reg;
    logic                  paf_own_reg;
    logic                  pae_own_reg;
    // output stage and flags
    logic [DATA_W-1:0]     out_data_reg;
    logic                  out_valid_reg;
    logic [NUM_QUEUES-1:0] af_n_reg;
    logic [NUM_QUEUES-1:0] ae_n_reg;
    logic [NUM_QUEUES-1:0] af_n_next;
    logic [NUM_QUEUES-1:0] ae_n_next;
    logic [NUM_QUEUES-1:0] af_bus_reg;
    logic [NUM_QUEUES-1:0] ae_bus_reg;
    logic                  af_sel_reg;
    logic                  ae_sel_reg;
    // queue store wiring
    logic [NUM_QUEUES-1:0] push_vec;
    logic [NUM_QUEUES-1:0] pop_vec;
    logic [NUM_QUEUES-1:0] in_ready_vec;
    logic [NUM_QUEUES-1:0] head_valid_vec;
    logic [DATA_W-1:0]     head_data [NUM_QUEUES];
    logic [CNT_W-1:0]      q_count [NUM_QUEUES];
    logic                  push;
    logic                  pop;
    logic                  force_rd;
    logic                  wr_me;
    logic                  rd_me;

    assign wr_me    = (wr_sel_dev == id_reg);
    assign rd_me    = (rd_sel_dev == id_reg);
    assign push     = wr_en && wr_own_reg && in_ready_vec[wr_q_reg];
    assign wr_ready = wr_own_reg && in_ready_vec[wr_q_reg];
    assign force_rd = (pend_reg && !pend_null_reg) || first_reg;
    // idle queue never pops
    // idle selection blocks the cycle-b read as well
    assign pop      = head_valid_vec[rd_q_reg] && rd_own_reg
                      && !rd_null_reg && !(pend_reg && pend_null_reg)
                      && (rd_en || !out_valid_reg || force_rd);

    genvar g;
    generate
        for (g = 0; g < NUM_QUEUES; g++)
        begin : g_q
            assign push_vec[g] = push && (wr_q_reg == g);
            assign pop_vec[g]  = pop && (rd_q_reg == g);
            // assert on count, release on next count
            assign af_n_next[g] = !((q_count[g] >= AF_THR)
                && (cnt_after(q_count[g], push_vec[g], pop_vec[g])
                    >= AF_THR));
            // same split for the empty side
            assign ae_n_next[g] = !((q_count[g] <= AE_THR)
                && (cnt_after(q_count[g], push_vec[g], pop_vec[g])
                    <= AE_THR));
            mqfe_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_q (
                .core_clk  (core_clk),
                .reset_n   (reset_n),
                .in_valid  (push_vec[g]),
                .in_ready  (in_ready_vec[g]),
                .in_data   (wr_data),
                .out_valid (head_valid_vec[g]),
                .out_ready (pop_vec[g]),
                .out_data  (head_data[g]),
                .count     (q_count[g])
            );
        end
    endgenerate

    // straps are sampled every cycle, under reset as well; these flops have no reset
    always_ff @(posedge core_clk)
    begin
        id_s1_reg  <= device_id_pin;
        id_reg     <= id_s1_reg;
        xin_s1_reg <= {full_expansion_in, empty_expansion_in};
        xin_reg    <= xin_s1_reg;
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            init_done_reg <= 1'b0;
            wr_q_reg      <= QSEL_RST;
            wr_own_reg    <= 1'b0;
            paf_own_reg   <= 1'b0;
            pae_own_reg   <= 1'b0;
        end
        else
        begin
            init_done_reg <= 1'b1;
            if (wr_sel_en)
            begin
                wr_q_reg   <= wr_sel_queue;
                wr_own_reg <= wr_me;
            end
            // each status bus starts owned when its own expansion-in strap is low, until selected away
            if (!init_done_reg)
            begin
                paf_own_reg <= !xin_reg[1];
                pae_own_reg <= !xin_reg[0];
            end
            else
            begin
                // ownership moves one cycle after selection
                if (paf_sel_en)
                    paf_own_reg <= wr_me;
                if (pae_sel_en)
                    pae_own_reg <= rd_me;
            end
        end
    end

    // read selection: captured, then applied one cycle later
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            pend_reg      <= 1'b0;
            pend_q_reg    <= QSEL_RST;
            pend_null_reg <= 1'b1;
            pend_own_reg  <= 1'b0;
            rd_q_reg      <= QSEL_RST;
            rd_null_reg   <= 1'b1;
            rd_own_reg    <= 1'b0;
            first_reg     <= 1'b0;
        end
        else
        begin
            pend_reg  <= rd_sel_en;
            first_reg <= pend_reg && !pend_null_reg;
            if (rd_sel_en)
            begin
                pend_q_reg    <= rd_sel_queue;
                pend_null_reg <= rd_sel_null;
                pend_own_reg  <= rd_me;
            end
            if (pend_reg)
            begin
                rd_q_reg    <= pend_q_reg;
                rd_null_reg <= pend_null_reg;
                rd_own_reg  <= pend_own_reg;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            out_data_reg  <= DATA_RST;
            out_valid_reg <= 1'b0;
        end
        else if (pop)
        begin
            out_data_reg  <= head_data[rd_q_reg];
            out_valid_reg <= 1'b1;
        end
        // idle queue: word held, marked invalid
        else if (rd_en || force_rd || (pend_reg && pend_null_reg))
            out_valid_reg <= 1'b0;
    end

    // flags use the selection from one cycle back: two-cycle switch
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            af_n_reg   <= FLAG_RST;
            ae_n_reg   <= FLAG_RST;
            af_bus_reg <= FLAG_RST;
            ae_bus_reg <= FLAG_RST;
            af_sel_reg <= 1'b1;
            ae_sel_reg <= 1'b1;
        end
        else
        begin
            af_n_reg   <= af_n_next;
            ae_n_reg   <= ae_n_next;
            af_bus_reg <= af_n_next;
            ae_bus_reg <= ae_n_next;
            // active flag tracks the registered write queue
            af_sel_reg <= af_n_next[wr_q_reg];
            ae_sel_reg <= ae_n_next[rd_q_reg] || rd_null_reg;
        end
    end

    // float what this device does not own
    assign data_out                   = out_data_reg;
    assign data_out_oe                = rd_own_reg;
    // high while the word shown is not valid
    assign output_valid_flag          = !out_valid_reg;
    assign output_valid_flag_oe       = rd_own_reg;
    // flags read low when almost full or almost empty
    assign almost_empty_flag          = ae_sel_reg;
    assign almost_empty_flag_oe       = rd_own_reg;
    assign almost_full_flag           = af_sel_reg;
    assign almost_full_flag_oe        = wr_own_reg;
    assign almost_full_status_bus     = af_bus_reg;
    assign almost_full_status_bus_oe  = paf_own_reg;
    assign almost_empty_status_bus    = ae_bus_reg;
    assign almost_empty_status_bus_oe = pae_own_reg;
    // polled mode is not built; these stay low
    assign full_expansion_out         = 1'b0;
    assign empty_expansion_out        = 1'b0;

    // checks
    null_hold_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        pend_reg && pend_null_reg |=> output_valid_flag
            && $stable(data_out) && !pop)
        else $error("idle queue did not hold the output");
    fall_thru_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        first_reg && rd_own_reg && head_valid_vec[rd_q_reg] |-> pop
            ##1 !output_valid_flag)
        else $error("new queue head did not fall through");
    ov_level_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        pop |=> !output_valid_flag
            && data_out == $past(head_data[rd_q_reg]))
        else $error("valid flag wrong after a read");
    af_rise_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        push && !wr_sel_en && !pop_vec[wr_q_reg]
            && q_count[wr_q_reg] == AF_THR - 5'h01
            ##1 !wr_sel_en && !pop_vec[wr_q_reg]
        |=> !almost_full_flag)
        else $error("almost full not seen two cycles after write");
    af_fall_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        pop && !push_vec[rd_q_reg] && q_count[rd_q_reg] == AF_THR
        |=> af_bus_reg[$past(rd_q_reg)])
        else $error("almost full not released one cycle after read");
    ae_rise_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        pop && !push_vec[rd_q_reg] && q_count[rd_q_reg] == AE_THR + 5'h01
            ##1 !push_vec[$past(rd_q_reg)] && !pend_reg
        |=> !ae_n_reg[$past(rd_q_reg, 2)])
        else $error("almost empty not seen two cycles after read");
    ae_fall_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        push && !pop_vec[wr_q_reg] && q_count[wr_q_reg] == AE_THR
        |=> ae_n_reg[$past(wr_q_reg)])
        else $error("almost empty not released one cycle after write");
    rd_float_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        pend_reg && !pend_own_reg |=> !data_out_oe
            && !almost_empty_flag_oe && !output_valid_flag_oe)
        else $error("unselected reader still drives");
    wr_float_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        wr_sel_en |=> almost_full_flag_oe == $past(wr_me))
        else $error("almost full flag drive wrong");
    pae_bus_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        init_done_reg && pae_sel_en
        |=> almost_empty_status_bus_oe == $past(rd_me)
            && almost_empty_status_bus == $past(ae_n_next))
        else $error("empty status bus hand-off wrong");
    paf_bus_a: assert property (@(posedge core_clk) disable iff (!reset_n)
        init_done_reg && paf_sel_en
        |=> almost_full_status_bus_oe == $past(wr_me))
        else $error("full status bus hand-off wrong");
    null_c: cover property (@(posedge core_clk) disable iff (!reset_n)
        pend_reg && pend_null_reg ##1 output_valid_flag);
    switch_c: cover property (@(posedge core_clk) disable iff (!reset_n)
        pend_reg && !pend_null_reg ##1 first_reg && pop);
    af_c: cover property (@(posedge core_clk) disable iff (!reset_n)
        !almost_full_flag && almost_full_flag_oe ##1 !wr_ready);
    bus_c: cover property (@(posedge core_clk) disable iff (!reset_n)
        $rose(almost_empty_status_bus_oe));
endmodule

// ===== mqfe_peer.sv
// Purpose: peer device sharing the read data bus and empty status bus
// Assumes: same selection timing as the block, device number PEER_ID
// Notes:   drives a toggling pattern, so a stale level is never seen
`timescale 1ns/1ns
module mqfe_peer
    import mqfe_pkg::*;
#(
    parameter logic [DEV_W-1:0] PEER_ID = 3'h2
)
(
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  reset_n,
    // read-port selections
    input  wire logic                  rd_sel_en,
    input  wire logic                  pae_sel_en,
    input  wire logic [DEV_W-1:0]      rd_sel_dev,
    // block drivers on the shared lines
    input  wire logic [DATA_W-1:0]     data_out,
    input  wire logic                  data_out_oe,
    input  wire logic [NUM_QUEUES-1:0] ae_bus_out,
    input  wire logic                  ae_bus_oe,
    // resolved lines
    output logic      [DATA_W-1:0]     data_bus,
    output logic      [NUM_QUEUES-1:0] ae_bus,
    output int                         clash
);
    logic             pend_reg;
    logic [DEV_W-1:0] pend_dev_reg;
    logic             own_rd_reg;
    logic             own_ae_reg;
    logic             pat_reg;

    // take over only as selection applies
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            pend_reg     <= 1'b0;
            pend_dev_reg <= '0;
            own_rd_reg   <= 1'b0;
            own_ae_reg   <= 1'b0;
            pat_reg      <= 1'b0;
            clash        <= 0;
        end
        else
        begin
            pend_reg <= rd_sel_en;
            pat_reg  <= ~pat_reg;
            if (rd_sel_en)
                pend_dev_reg <= rd_sel_dev;
            if (pend_reg)
                own_rd_reg <= (pend_dev_reg == PEER_ID);
            if (pae_sel_en)
                own_ae_reg <= (rd_sel_dev == PEER_ID);
            clash <= clash + int'((own_rd_reg && data_out_oe)
                                  || (own_ae_reg && ae_bus_oe));
        end
    end

    // bit q of each device joins bit q of the bus
    assign data_bus = data_out_oe ? data_out
                    : own_rd_reg ? {DATA_W{pat_reg}} : 'z;
    assign ae_bus   = ae_bus_oe ? ae_bus_out
                    : own_ae_reg ? {NUM_QUEUES{pat_reg}} : 'z;
endmodule

// ===== tb_multi_queue_flag_expansion.sv
// Purpose: self-checking bench for queue selection, flags and buses
// Assumes: block is device 1, empty-bus master, peer is device 2
// Notes:   inputs change and outputs are checked on the falling edge
`timescale 1ns/1ns
`define CHK(nm, e, g) \
begin \
    cmp_count++; \
    if ((g) !== (e)) \
    begin \
        errors++; \
        $display("MISMATCH %s exp=%h got=%h", nm, e, g); \
    end \
end
module tb_multi_queue_flag_expansion;
    import mqfe_pkg::*;
    localparam logic [DEV_W-1:0] ME    = 3'h1;
    localparam logic [DEV_W-1:0] PEER  = 3'h2;
    localparam int               LIMIT = 2000;
    logic                  core_clk, reset_n, wr_sel_en, paf_sel_en;
    logic                  wr_en, rd_sel_en, pae_sel_en, rd_sel_null;
    logic                  rd_en, wr_ready, data_out_oe;
    logic                  full_expansion_out, empty_expansion_out;
    logic [DEV_W-1:0]      wr_sel_dev, rd_sel_dev;
    logic [QSEL_W-1:0]     wr_sel_queue, rd_sel_queue;
    logic [DATA_W-1:0]     wr_data, data_out, data_bus, last;
    logic                  almost_full_flag, almost_full_flag_oe;
    logic [NUM_QUEUES-1:0] almost_full_status_bus, ae_bus;
    logic [NUM_QUEUES-1:0] almost_empty_status_bus;
    logic                  almost_full_status_bus_oe;
    logic                  output_valid_flag, output_valid_flag_oe;
    logic                  almost_empty_flag, almost_empty_flag_oe;
    logic                  almost_empty_status_bus_oe;
    int                    errors, cmp_count, cycles, clash, n;
    logic [DATA_W-1:0]     exp_q[$];

    mqfe_top uut (
        .core_clk, .reset_n, .device_id_pin(ME),
        .full_expansion_in(1'b1), .empty_expansion_in(1'b0),
        .full_expansion_out, .empty_expansion_out, .wr_sel_en,
        .paf_sel_en, .wr_sel_dev, .wr_sel_queue, .wr_en, .wr_data,
        .wr_ready, .almost_full_flag, .almost_full_flag_oe,
        .almost_full_status_bus, .almost_full_status_bus_oe,
        .rd_sel_en, .pae_sel_en, .rd_sel_dev, .rd_sel_queue,
        .rd_sel_null, .rd_en, .data_out, .data_out_oe,
        .output_valid_flag, .output_valid_flag_oe, .almost_empty_flag,
        .almost_empty_flag_oe, .almost_empty_status_bus,
        .almost_empty_status_bus_oe
    );

    mqfe_peer #(.PEER_ID(PEER)) peer (
        .core_clk, .reset_n, .rd_sel_en, .pae_sel_en, .rd_sel_dev,
        .data_out, .data_out_oe, .ae_bus_out(almost_empty_status_bus),
        .ae_bus_oe(almost_empty_status_bus_oe), .data_bus, .ae_bus,
        .clash
    );

    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic report_and_stop();
        $display("errors=%0d compares=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // a hang counts as a mismatch
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            errors++;
            report_and_stop();
        end
    end

    task automatic cyc(int k);
        repeat (k) @(negedge core_clk);
    endtask

    // callers leave two cycles between read selects
    task automatic sel(int k, logic [DEV_W-1:0] d, logic [QSEL_W-1:0] q,
                       logic nul);
        // only the strobe in use is touched, once per edge
        if (k == 0) wr_sel_en = 1'b1;
        else if (k == 1) paf_sel_en = 1'b1;
        else if (k == 2) rd_sel_en = 1'b1;
        else pae_sel_en = 1'b1;
        {wr_sel_dev, rd_sel_dev} = {d, d};
        {wr_sel_queue, rd_sel_queue} = {q, q};
        rd_sel_null = nul;
        cyc(1);
        if (k == 0) wr_sel_en = 1'b0;
        else if (k == 1) paf_sel_en = 1'b0;
        else if (k == 2) rd_sel_en = 1'b0;
        else pae_sel_en = 1'b0;
    endtask

    // write enable held high across k back-to-back writes
    task automatic wrn(int k, output int acc);
        acc   = 0;
        wr_en = 1'b1;
        repeat (k)
        begin
            wr_data = DATA_W'($urandom);
            if (wr_ready === 1'b1)
            begin
                exp_q.push_back(wr_data);
                acc++;
            end
            cyc(1);
        end
        wr_en = 1'b0;
    endtask

    task automatic rd1();
        rd_en = 1'b1;
        cyc(1);
        rd_en = 1'b0;
    endtask

    task automatic look();
        last = exp_q.pop_front();
        `CHK("data", last, data_bus)
        `CHK("valid", 1'b0, output_valid_flag)
    endtask

    // stalls nothing: reads until the queue runs dry
    task automatic drain();
        sel(2, ME, 2'h1, 1'b0);
        cyc(1);
        `CHK("rd_oe", 1'b1, data_out_oe)
        cyc(1);
        rd_en = 1'b1;
        while (exp_q.size() > 0)
        begin
            look();
            cyc(1);
        end
        rd_en = 1'b0;
        `CHK("empty_valid", 1'b1, output_valid_flag)
        `CHK("held", last, data_bus)
    endtask

    initial
    begin
        {wr_sel_en, paf_sel_en, wr_en, rd_sel_en} = 4'h0;
        {pae_sel_en, rd_sel_null, rd_en} = 3'h0;
        {wr_sel_dev, rd_sel_dev, wr_sel_queue, rd_sel_queue} = 10'h000;
        wr_data = DATA_RST;
        reset_n = 1'b0;
        void'($urandom(41));
        cyc(16);
        `CHK("rst_rd_oe", 1'b0, data_out_oe)
        `CHK("rst_af_oe", 1'b0, almost_full_flag_oe)
        `CHK("rst_valid", 1'b1, output_valid_flag)
        `CHK("rst_afs", 4'hf, almost_full_status_bus)
        reset_n = 1'b1;
        cyc(3);
        `CHK("aes_master", 1'b1, almost_empty_status_bus_oe)
        `CHK("aes_empty", 4'h0, ae_bus)
        `CHK("afs_slave", 1'b0, almost_full_status_bus_oe)
        `CHK("xout", 2'h0, {full_expansion_out, empty_expansion_out})
        $display("test 1 done");
        sel(0, ME, 2'h1, 1'b0);
        `CHK("af_oe_on", 1'b1, almost_full_flag_oe)
        `CHK("wr_ready", 1'b1, wr_ready)
        sel(1, ME, 2'h0, 1'b0);
        `CHK("afs_oe_on", 1'b1, almost_full_status_bus_oe)
        wrn(11, n);
        `CHK("af_below", 1'b1, almost_full_flag)
        cyc(1);
        wrn(1, n);
        `CHK("af_edge1", 1'b1, almost_full_flag)
        cyc(1);
        `CHK("af_edge2", 1'b0, almost_full_flag)
        `CHK("afs_q1", 4'hd, almost_full_status_bus)
        wrn(1, n);
        $display("test 2 done");
        sel(0, ME, 2'h0, 1'b0);
        `CHK("af_sw_hold", 1'b0, almost_full_flag)
        cyc(1);
        `CHK("af_sw", 1'b1, almost_full_flag)
        sel(0, ME, 2'h1, 1'b0);
        cyc(1);
        `CHK("af_sw_back", 1'b0, almost_full_flag)
        $display("test 3 done");
        sel(2, ME, 2'h1, 1'b0);
        cyc(2);
        look();
        `CHK("af_fall", 1'b0, almost_full_flag)
        `CHK("ae_high", 1'b1, almost_empty_flag)
        rd1();
        `CHK("af_release", 1'b1, almost_full_flag)
        `CHK("afs_release", 4'hf, almost_full_status_bus)
        cyc(1);
        rd_en = 1'b1;
        repeat (7)
        begin
            look();
            cyc(1);
        end
        rd_en = 1'b0;
        `CHK("ae_edge1", 1'b1, almost_empty_flag)
        cyc(1);
        `CHK("ae_edge2", 1'b0, almost_empty_flag)
        `CHK("aes_q1", 4'h0, ae_bus)
        look();
        wrn(1, n);
        `CHK("ae_release", 1'b1, almost_empty_flag)
        `CHK("aes_release", 4'h2, ae_bus)
        $display("test 4 done");
        // read held through the idle selection: no extra word
        rd_en = 1'b1;
        sel(2, ME, 2'h0, 1'b1);
        look();
        cyc(1);
        `CHK("null_valid", 1'b1, output_valid_flag)
        rd1();
        `CHK("null_held", last, data_bus)
        `CHK("null_ae", 1'b1, almost_empty_flag)
        cyc(1);
        drain();
        $display("test 5 done");
        sel(2, ME, 2'h0, 1'b1);
        cyc(2);
        wrn(20, n);
        `CHK("fill_count", FIFO_DEPTH, n)
        `CHK("fill_af", 1'b0, almost_full_flag)
        drain();
        $display("test 6 done");
        sel(3, PEER, 2'h0, 1'b0);
        `CHK("aes_oe_off", 1'b0, almost_empty_status_bus_oe)
        sel(2, PEER, 2'h0, 1'b0);
        cyc(1);
        `CHK("rd_oe_off", 1'b0, data_out_oe)
        `CHK("ov_oe_off", 1'b0, output_valid_flag_oe)
        `CHK("ae_oe_off", 1'b0, almost_empty_flag_oe)
        sel(0, PEER, 2'h0, 1'b0);
        `CHK("af_oe_off", 1'b0, almost_full_flag_oe)
        `CHK("wr_refused", 1'b0, wr_ready)
        sel(3, ME, 2'h0, 1'b0);
        `CHK("aes_oe_on", 1'b1, almost_empty_status_bus_oe)
        `CHK("aes_back", 4'h0, ae_bus)
        sel(1, PEER, 2'h0, 1'b0);
        `CHK("afs_oe_off", 1'b0, almost_full_status_bus_oe)
        cyc(2);
        `CHK("no_clash", 0, clash)
        $display("test 7 done");
        report_and_stop();
    end
endmodule
